/* File: design/udt_defines.vh */
/*
  Constants of the 16-bit up/down reload timer: register offsets, mode fields, reset values, prescale counts.
  Assumes it is included by bare name from the design and bench files.
*/
// Summary of operation
// - Timer mode decrements per source tick
// - Source select: div1, div8, div32, sub32
// - High gate: count only while pin high
// - Gate low freezes counter value
// - Timer underflow reloads and requests interrupt
// - Clearing run flag holds the count
// - Pulse output toggles on underflow
// - Run flag clear forces output low
// - Event source: falling, rising, overflow inputs
// - Falling-edge selection counts each falling edge
// - Direction from flag or output pin
// - Direction change applies at next edge
// - Reload type reloads on under/overflow
// - Free-run wraps yet requests interrupt
// - Quadrature only on timers two-four
// - x1: out high, in rise up
// - x4 table of up and down
// - Prescalers main div 1/8/32, sub div32
// - Write while running updates reload only
// - Counter read returns live 16-bit count
`ifndef UDT_DEFINES_VH
`define UDT_DEFINES_VH

// ==========================================================
// Register offsets
`define UDT_ADDR_W        4
`define UDT_REG_COUNT     4'h0
`define UDT_REG_MODE      4'h1
`define UDT_REG_CTRL      4'h2
`define UDT_REG_STATUS    4'h3

// ==========================================================
// Mode register fields
`define UDT_MODE_OP_LO    0
`define UDT_MODE_OP_HI    1
`define UDT_MODE_SRC_LO   2
`define UDT_MODE_SRC_HI   3
`define UDT_MODE_GATE     4
`define UDT_MODE_PULSE    5
`define UDT_MODE_FREE     6
`define UDT_MODE_DIRPIN   7
`define UDT_MODE_X4       8
`define UDT_MODE_W        9
`define UDT_MODE_RST      9'h000

// Operating modes
`define UDT_OP_TIMER      2'h0
`define UDT_OP_EVENT      2'h1
`define UDT_OP_QUAD       2'h2

// Source selections (clock in timer mode, event in event mode)
`define UDT_SRC_DIV1      2'h0
`define UDT_SRC_DIV8      2'h1
`define UDT_SRC_DIV32     2'h2
`define UDT_SRC_SUB32     2'h3
`define UDT_EV_FALL       2'h0
`define UDT_EV_RISE       2'h1
`define UDT_EV_BTIMER     2'h2
`define UDT_EV_PREV       2'h3

// Control register fields
`define UDT_CTRL_RUN      0
`define UDT_CTRL_UP       1
`define UDT_CTRL_RST      2'h0

// Status fields
`define UDT_STAT_IRQ      0
`define UDT_STAT_OUT      1
`define UDT_STAT_DIR      2

// ==========================================================
// Prescaler counts
`define UDT_DIV8          8
`define UDT_DIV32         32
`define UDT_CNT_RST       16'hffff

`endif

/* File: design/udt_sync.v */
/*
  Two-flop synchroniser with registered edge detect.
  Assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module udt_sync (
  // Clock and reset
  input  wire sys_clk_i,
  input  wire rst_b_i,
  // Pin
  input  wire pin_i,
  // Outputs
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // First flop feeds only the second
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* File: design/udt_prescaler.v */
/*
  Prescaler: one-cycle enables at main/1, main/8, main/32 and sub/32.
  Assumes the sub clock arrives as a one-cycle tick enable on sys_clk_i.
*/
`include "udt_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module udt_prescaler (
  // Clock and reset
  input  wire sys_clk_i,
  input  wire rst_b_i,
  // Sub clock tick
  input  wire sub_tick_i,
  // Enables
  output wire main_clock_div1_o,
  output wire main_clock_div8_o,
  output wire main_clock_div32_o,
  output wire sub_clock_div32_o
);
  reg [4:0] main_cnt_q;
  reg [4:0] sub_cnt_q;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_cnt_q <= 5'h00;
      sub_cnt_q  <= 5'h00;
    end else begin
      main_cnt_q <= main_cnt_q + 5'h01;
      if (sub_tick_i) begin
        sub_cnt_q <= sub_cnt_q + 5'h01;
      end
    end
  end

  assign main_clock_div1_o  = 1'b1;
  assign main_clock_div8_o  = (main_cnt_q[2:0] == 3'h7);
  assign main_clock_div32_o = (main_cnt_q == 5'h1f);
  assign sub_clock_div32_o  = sub_tick_i & (sub_cnt_q == 5'h1f);
endmodule
`default_nettype wire

/* File: design/udt_timer.v */
/*
  16-bit up/down reload timer: timer mode with gate and pulse output, event counting
  (reload or free-run), two-phase decoding at x1 or x4.
  Assumes pins are synchronous-capable inputs, a sub clock tick enable and
  neighbour overflow pulses on sys_clk_i. One-shot and PWM modes are not built.
*/
// Local design decisions: the plain strobed port and the address map.
`include "udt_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module udt_timer #(
  parameter        QUAD_X1 = 1, // two-phase x1 allowed
  parameter        QUAD_X4 = 1  // two-phase x4 allowed
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  // Register port
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  // Count sources
  input  wire        sub_tick_i,
  input  wire        b_group_timer_two_ovf_i,
  input  wire        preceding_a_timer_ovf_i,
  // Pins
  input  wire        timer_input_pin_i,
  input  wire        timer_output_pin_i,
  output wire        timer_output_pin_o,
  output wire        timer_output_pin_oe_b_o,
  // Events
  output reg         irq_req_o,
  output reg         overflow_o
);

  // ==========================================================
  // Registers
  reg [15:0]             counter_q;
  reg [15:0]             reload_q;
  reg [`UDT_MODE_W-1:0]  mode_q;
  reg                    run_q;
  reg                    up_flag_q;
  reg                    pout_q;
  reg                    dir_up_q;

  wire [1:0] op_mode  = mode_q[`UDT_MODE_OP_HI:`UDT_MODE_OP_LO];
  wire [1:0] src_sel  = mode_q[`UDT_MODE_SRC_HI:`UDT_MODE_SRC_LO];
  wire       gate_en  = mode_q[`UDT_MODE_GATE];
  wire       pulse_en = mode_q[`UDT_MODE_PULSE];
  wire       free_run = mode_q[`UDT_MODE_FREE];
  wire       dir_pin  = mode_q[`UDT_MODE_DIRPIN];
  wire       x4_sel   = mode_q[`UDT_MODE_X4];

  // ==========================================================
  // Prescaler and pin synchronisers
  wire div1_en;
  wire div8_en;
  wire div32_en;
  wire sub32_en;

  udt_prescaler u_pre (
    .sys_clk_i          (sys_clk_i),
    .rst_b_i            (rst_b_i),
    .sub_tick_i         (sub_tick_i),
    .main_clock_div1_o  (div1_en),
    .main_clock_div8_o  (div8_en),
    .main_clock_div32_o (div32_en),
    .sub_clock_div32_o  (sub32_en)
  );

  wire in_lvl;
  wire in_rise;
  wire in_fall;
  wire ph_lvl;
  wire ph_rise;
  wire ph_fall;

  udt_sync u_sync_in (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (timer_input_pin_i),
    .level_o   (in_lvl),
    .rise_o    (in_rise),
    .fall_o    (in_fall)
  );

  udt_sync u_sync_ph (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (timer_output_pin_i),
    .level_o   (ph_lvl),
    .rise_o    (ph_rise),
    .fall_o    (ph_fall)
  );

  // ==========================================================
  // Count enable and direction
  reg tick;
  always @* begin
    case (src_sel)
      `UDT_SRC_DIV1:  tick = div1_en;
      `UDT_SRC_DIV8:  tick = div8_en;
      `UDT_SRC_DIV32: tick = div32_en;
      default:        tick = sub32_en;
    endcase
  end

  reg ev_edge;
  always @* begin
    case (src_sel)
      `UDT_EV_FALL:   ev_edge = in_fall;
      `UDT_EV_RISE:   ev_edge = in_rise;
      `UDT_EV_BTIMER: ev_edge = b_group_timer_two_ovf_i;
      default:        ev_edge = preceding_a_timer_ovf_i;
    endcase
  end

  // Direction source; in pin mode the output pin is read as an input
  wire dir_now = dir_pin ? ph_lvl : up_flag_q;

  // Quadrature decode
  // Both phases share one sync latency, so x4 sees one change per step
  wire quad_ok = x4_sel ? (QUAD_X4 != 0) : (QUAD_X1 != 0);
  wire x1_up   = ph_lvl & in_rise;
  wire x1_dn   = ph_lvl & in_fall;
  wire x4_up   = (ph_lvl & in_rise) | (~ph_lvl & in_fall) |
                 (ph_rise & ~in_lvl) | (ph_fall & in_lvl);
  wire x4_dn   = (ph_lvl & in_fall) | (~ph_lvl & in_rise) |
                 (ph_rise & in_lvl) | (ph_fall & ~in_lvl);
  wire q_up    = quad_ok & (x4_sel ? x4_up : x1_up);
  wire q_dn    = quad_ok & (x4_sel ? x4_dn : x1_dn);

  reg step;
  reg step_up;
  always @* begin
    step    = 1'b0;
    step_up = 1'b0;
    case (op_mode)
      `UDT_OP_TIMER: begin
        step = run_q & tick & (~gate_en | in_lvl);
      end
      `UDT_OP_EVENT: begin
        step    = run_q & ev_edge;
        step_up = dir_now;
      end
      `UDT_OP_QUAD: begin
        step    = run_q & (q_up ^ q_dn);
        step_up = q_up;
      end
      default: begin
        step = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Wrap detection
  localparam [15:0] CNT_MIN = 16'h0000;
  localparam [15:0] CNT_MAX = 16'hffff;

  wire under   = step & ~step_up & (counter_q == CNT_MIN);
  wire over    = step & step_up & (counter_q == CNT_MAX);
  wire wrap    = under | over;
  wire reload_on_wrap = (op_mode == `UDT_OP_TIMER) | ((op_mode == `UDT_OP_EVENT) & ~free_run);

  // ==========================================================
  // Write decode
  wire wr_count = wr_i & (addr_i == `UDT_REG_COUNT);
  wire wr_mode  = wr_i & (addr_i == `UDT_REG_MODE);
  wire wr_ctrl  = wr_i & (addr_i == `UDT_REG_CTRL);
  wire wr_stat  = wr_i & (addr_i == `UDT_REG_STATUS);

  // ==========================================================
  // Next counter value
  reg [15:0] counter_d;
  always @* begin
    counter_d = counter_q;
    if (wr_count & ~run_q) begin
      counter_d = wdata_i;
    end else if (step) begin
      if (wrap & reload_on_wrap) begin
        counter_d = reload_q;
      end else if (step_up) begin
        counter_d = counter_q + 16'h0001;
      end else begin
        counter_d = counter_q - 16'h0001;
      end
    end
  end

  // Pulse output toggles on wrap, low while stopped
  reg pout_d;
  always @* begin
    pout_d = pout_q;
    if (~run_q | ~pulse_en) begin
      pout_d = 1'b0;
    end else if (wrap) begin
      pout_d = ~pout_q;
    end
  end

  // Set wins over a software clear in the same cycle
  reg irq_d;
  always @* begin
    irq_d = irq_req_o;
    if (wrap) begin
      irq_d = 1'b1;
    end else if (wr_stat & ~wdata_i[`UDT_STAT_IRQ]) begin
      irq_d = 1'b0;
    end
  end

  // Status direction follows the last counted event-mode edge, or live while stopped
  reg dir_up_d;
  always @* begin
    dir_up_d = dir_up_q;
    if (~run_q | (step & (op_mode == `UDT_OP_EVENT))) begin
      dir_up_d = dir_now;
    end
  end

  // ==========================================================
  // Mode register
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= `UDT_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= wdata_i[`UDT_MODE_W-1:0];
    end
  end

  // Control register; run low after reset keeps the counter still
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {up_flag_q, run_q} <= `UDT_CTRL_RST;
    end else if (wr_ctrl) begin
      run_q     <= wdata_i[`UDT_CTRL_RUN];
      up_flag_q <= wdata_i[`UDT_CTRL_UP];
    end
  end

  // Reload always takes a count write
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload_q <= `UDT_CNT_RST;
    end else if (wr_count) begin
      reload_q <= wdata_i;
    end
  end

  // Count held whenever step is low and no count write lands while stopped
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_q <= `UDT_CNT_RST;
    end else begin
      counter_q <= counter_d;
    end
  end

  // Status flags
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_up_q  <= 1'b0;
      pout_q    <= 1'b0;
      irq_req_o <= 1'b0;
    end else begin
      dir_up_q  <= dir_up_d;
      pout_q    <= pout_d;
      irq_req_o <= irq_d;
    end
  end

  // One-cycle wrap pulse, usable as a neighbour's event source
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= wrap;
    end
  end

  // Pin drives only with pulse output in timer mode; elsewhere it is an input
  assign timer_output_pin_o      = pout_q;
  assign timer_output_pin_oe_b_o = ~(pulse_en & (op_mode == `UDT_OP_TIMER));

  // ==========================================================
  // Read port
  reg [15:0] rdata_d;
  always @* begin
    case (addr_i)
      `UDT_REG_COUNT:  rdata_d = counter_q;
      `UDT_REG_MODE:   rdata_d = {{(16-`UDT_MODE_W){1'b0}}, mode_q};
      `UDT_REG_CTRL:   rdata_d = {14'h0, up_flag_q, run_q};
      `UDT_REG_STATUS: rdata_d = {13'h0, dir_up_q, pout_q, irq_req_o};
      default:         rdata_d = 16'h0000;
    endcase
  end

  // Data only in the cycle after the strobe, zero otherwise
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: bench/udt_timer_sva.sv */
/* Port checker for udt_timer.
   Assumes a bind onto every udt_timer instance. */
`include "udt_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module udt_timer_chk (
  // Clock, reset and bus
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // Pin and events
  input wire logic        timer_output_pin_o,
  input wire logic        timer_output_pin_oe_b_o,
  input wire logic        irq_req_o,
  input wire logic        overflow_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========
  // Assertions
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  AST_RD_UNMAP: assert property ($past(rd_i) && $past(addr_i) > `UDT_REG_STATUS |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_IRQ: assert property ($past(rd_i) && $past(addr_i) == `UDT_REG_STATUS |-> rdata_o[0] == $past(irq_req_o))
    else $error("status read lost request");
  AST_IRQ_SET: assert property ($rose(irq_req_o) |-> ##[0:1] (overflow_o || $past(overflow_o)))
    else $error("request without wrap");
  AST_IRQ_CLR: assert property ($fell(irq_req_o) |->
    $past(wr_i) && $past(addr_i) == `UDT_REG_STATUS && !$past(wdata_i[0]))
    else $error("request dropped without clear");
  AST_OUT_RISE: assert property ($rose(timer_output_pin_o) |-> ##[0:1] (overflow_o || $past(overflow_o)))
    else $error("output rose without wrap");
  AST_OE_OFF: assert property ($past(wr_i) && $past(addr_i) == `UDT_REG_MODE &&
    !$past(wdata_i[`UDT_MODE_PULSE]) |-> ##[0:1] timer_output_pin_oe_b_o)
    else $error("pin driven without pulse option");
  AST_RUN_OFF: assert property ($past(wr_i) && $past(addr_i) == `UDT_REG_CTRL &&
    !$past(wdata_i[`UDT_CTRL_RUN]) |-> ##[0:1] !timer_output_pin_o)
    else $error("output not low after stop");
endmodule
bind udt_timer udt_timer_chk u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .timer_output_pin_o(timer_output_pin_o),
  .timer_output_pin_oe_b_o(timer_output_pin_oe_b_o), .irq_req_o(irq_req_o), .overflow_o(overflow_o)
);
`default_nettype wire

/* File: bench/udt_pins.sv */
/* Far-side pin model: pulse source and two-phase encoder.
   Assumes its tasks are called right after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module udt_pins (
  // Clock
  input wire logic sys_clk_i,
  // Pins
  output var logic in_pin_o,
  output var logic phase_o
);
  logic [1:0] pos = 2'h3;
  initial begin
    in_pin_o = 1'b0;
    phase_o  = 1'b0;
  end
  // Six cycles, beyond two source periods
  task automatic lvl(input logic v);
    in_pin_o <= v;
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic pulse();
    lvl(1'b1);
    lvl(1'b0);
  endtask
  // Up order of phase,input: 10 11 01 00
  task automatic step(input logic up);
    pos = up ? pos + 2'h1 : pos - 2'h1;
    phase_o <= (pos < 2'h2);
    lvl(pos == 2'h1 || pos == 2'h2);
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
/* Self-checking bench for udt_timer.
   Assumes udt_defines.vh on the include path. */
`include "udt_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [3:0] CN = `UDT_REG_COUNT, MD = `UDT_REG_MODE, CT = `UDT_REG_CTRL, ST = `UDT_REG_STATUS;
  logic        clk, rst_b, wr, rd, btv, prv, pout, oe_b, irq, ovf, p1;
  logic        sub = 1'b0;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d, e;
  wire         in_pin, phase;
  wire         opin = oe_b ? phase : pout;
  integer      seed = 29521;
  int          failures = 0, compares = 0, n, t, s, k;
  int          dv [4] = '{1, `UDT_DIV8, `UDT_DIV32, 2 * `UDT_DIV32};
  udt_timer DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .sub_tick_i(sub), .b_group_timer_two_ovf_i(btv), .preceding_a_timer_ovf_i(prv),
    .timer_input_pin_i(in_pin), .timer_output_pin_i(opin), .timer_output_pin_o(pout),
    .timer_output_pin_oe_b_o(oe_b), .irq_req_o(irq), .overflow_o(ovf));
  udt_pins pins (.sys_clk_i(clk), .in_pin_o(in_pin), .phase_o(phase));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_ovf();
    t = 0;
    @(posedge clk);
    while (ovf !== 1'b1 && t < 5000) begin
      @(posedge clk);
      t++;
    end
    if (ovf !== 1'b1) begin
      failures++;
      $display("unexpected overflow expected 1 seen %b", ovf);
    end
  endtask
  task automatic ev(input int src);
    if (src < 2) pins.pulse();
    else begin
      @(posedge clk);
      btv <= (src == 2);
      prv <= (src == 3);
      @(posedge clk);
      btv <= 1'b0;
      prv <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) sub <= ~sub;
  initial begin
    #300000;
    failures++;
    report_and_stop();
  end
  initial begin
    {rst_b, wr, rd, btv, prv, addr, wdata} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 4; k++) begin
      rd_reg(k == 3 ? 4'h9 : 4'(k));
      chk("reset", k == 0 ? `UDT_CNT_RST : 16'h0000, d);
    end
    for (s = 0; s < 4; s++) begin
      n = 2 + ($random(seed) & 7);
      wr_reg(CT, 16'h0000);
      wr_reg(CN, 16'(n));
      wr_reg(MD, 16'(s << `UDT_MODE_SRC_LO));
      wr_reg(CT, 16'h0001);
      wait_ovf();
      wait_ovf();
      chk("period", 16'((n + 1) * dv[s]), 16'(t + 1));
    end
    wr_reg(MD, 16'h0020);
    wr_reg(CN, 16'h0005);
    wait_ovf();
    wait_ovf();
    #1 p1 = pout;
    wait_ovf();
    chk("live period", 16'h0006, 16'(t + 1));
    #1 chk("toggle", {15'h0, ~p1}, {15'h0, pout});
    chk("drive", 16'h0000, {15'h0, oe_b});
    wr_reg(CT, 16'h0000);
    repeat (2) @(posedge clk);
    chk("stop out", 16'h0000, {15'h0, pout});
    rd_reg(CN);
    e = d;
    repeat (20) @(posedge clk);
    rd_reg(CN);
    chk("held", e, d);
    wr_reg(CN, 16'h1234);
    rd_reg(CN);
    chk("stop write", 16'h1234, d);
    wr_reg(MD, 16'h0010);
    wr_reg(CT, 16'h0001);
    repeat (20) @(posedge clk);
    rd_reg(CN);
    chk("gate low", 16'h1234, d);
    pins.lvl(1'b1);
    pins.lvl(1'b0);
    rd_reg(CN);
    chk("gate high", 16'h122e, d);
    for (s = 0; s < 4; s++) begin
      wr_reg(CT, 16'h0000);
      wr_reg(CN, 16'h000a);
      wr_reg(MD, 16'(`UDT_OP_EVENT | s << `UDT_MODE_SRC_LO));
      wr_reg(CT, 16'h0001);
      for (k = 0; k < 3; k++) ev(s);
      if (s < 2) pins.lvl(1'b1);
      rd_reg(CN);
      chk("events", s == 1 ? 16'h0006 : 16'h0007, d);
      pins.lvl(1'b0);
    end
    wr_reg(CT, 16'h0000);
    wr_reg(CN, 16'h0001);
    wr_reg(MD, 16'h0009);
    wr_reg(ST, 16'h0000);
    wr_reg(CT, 16'h0001);
    ev(2);
    ev(2);
    rd_reg(ST);
    chk("reload irq", 16'h0001, {15'h0, d[`UDT_STAT_IRQ]});
    wr_reg(CT, 16'h0003);
    for (k = 0; k < 3; k++) ev(2);
    rd_reg(CN);
    chk("direction", 16'h0004, d);
    wr_reg(CT, 16'h0002);
    wr_reg(CN, 16'hffff);
    wr_reg(MD, 16'h0049);
    wr_reg(ST, 16'h0000);
    wr_reg(CT, 16'h0003);
    ev(2);
    rd_reg(CN);
    chk("free wrap", 16'h0000, d);
    rd_reg(ST);
    chk("free irq", 16'h0001, {15'h0, d[`UDT_STAT_IRQ]});
    chk("irq out", 16'h0001, {15'h0, irq});
    wr_reg(CT, 16'h0000);
    wr_reg(CN, 16'h0064);
    wr_reg(MD, 16'h0102);
    wr_reg(CT, 16'h0001);
    for (s = 0; s < 2; s++) begin
      for (k = 0; k < 12; k++) pins.step(k < 8);
      rd_reg(CN);
      chk("two-phase", s == 0 ? 16'h0068 : 16'h0069, d);
      wr_reg(MD, 16'h0002);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
